/* File: logic/axm_consts.svh */
// Constants for the auxiliary RAM map: register indices, field positions, reset values, counts.
// Assumes it is included by the map module and the bench by its bare name.
`ifndef AXM_CONSTS_SVH
`define AXM_CONSTS_SVH

// Register indices; the APB byte address is four times the index.
`define AXM_IDX_SP_LOW      8'h81
`define AXM_IDX_SP_HIGH     8'hef
`define AXM_IDX_PAGE        8'hf6
`define AXM_IDX_AUX_CTRL    8'h8e
`define AXM_IDX_AUX_CTRL2   8'ha2
`define AXM_IDX_NV_CTRL     8'hd2

// Field positions.
`define AXM_BYPASS_BIT      1
`define AXM_SIZE_LSB        2
`define AXM_SIZE_MSB        4
`define AXM_NV_WINDOW_BIT   1
`define AXM_EXTENDED_STACK_ENABLE_BIT        4

// Reset values.
`define AXM_RST_SP_LOW      8'h07
`define AXM_RST_SP_HIGH     3'h0
`define AXM_RST_PAGE        8'h00
`define AXM_RST_AUX_CTRL    8'h08
`define AXM_RST_AUX_CTRL2   8'h00
`define AXM_RST_NV_CTRL     8'h00

// Size select codes and the resulting RAM limits in bytes.
`define AXM_CODE_256        3'h0
`define AXM_CODE_512        3'h1
`define AXM_CODE_768        3'h2
`define AXM_CODE_1024       3'h3
`define AXM_CODE_1152       3'h4
`define AXM_LIMIT_256       12'h100
`define AXM_LIMIT_512       12'h200
`define AXM_LIMIT_768       12'h300
`define AXM_LIMIT_1024      12'h400
`define AXM_LIMIT_1152      12'h480

// Highest page that still maps onto the internal RAM.
`define AXM_PAGE_MAX        8'h07

// Wait counts loaded at acceptance: a move hit, an extended stack access.
`define AXM_MOVE_WAIT       2'h1
`define AXM_EXTENDED_STACK_ENABLE_WAIT       2'h2

`endif

/* File: logic/axm_pkg.sv */
// Types shared by the auxiliary RAM map and the far-side model of the bench.
// Assumes axm_consts.svh is available on the include path.
package axm_pkg;

    typedef enum logic [1:0] {
        AXM_IDLE = 2'h0,
        AXM_RAM  = 2'h1,
        AXM_EXT  = 2'h3,
        AXM_IDA  = 2'h2
    } axm_state_t;

    typedef struct packed {
        logic        wide;
        logic        write;
        logic [15:0] addr16;
        logic [7:0]  addr8;
        logic [7:0]  wdata;
    } axm_move_t;

    typedef struct packed {
        logic        push;
        logic [7:0]  wdata;
    } axm_stack_t;

    typedef struct packed {
        logic [15:0] addr;
        logic        write;
        logic [7:0]  wdata;
    } axm_ext_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic        write;
        logic [7:0]  wdata;
    } axm_internal_data_space_t;

endpackage

/* File: logic/axm_ram.sv */
// Auxiliary RAM array with one synchronous read/write port.
// Assumes a single clock; read data is valid the cycle after an enabled read.
module axm_ram #(
    parameter int unsigned ADDR_W = 11,
    parameter int unsigned DATA_W = 8
) (
    input  wire logic              pclk,
    input  wire logic              en,
    input  wire logic              we,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    output logic      [DATA_W-1:0] rdata
);

    logic [DATA_W-1:0] mem [2**ADDR_W];

    // The array holds no reset; contents are undefined until written.
    always_ff @(posedge pclk) begin
        if (en) begin
            if (we) begin
                mem[addr] <= wdata;
            end
            rdata <= mem[addr];
        end
    end

endmodule // axm_ram

/* File: logic/axm_map.sv */
// Address map and control for the auxiliary RAM and the extended stack, with an APB slave.
// Assumes a core that pulses requests only while busy is low, and single-clock peripherals.
module axm_map
    import axm_pkg::*;
#(
    parameter int unsigned RAM_ADDR_W = 11
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic [11:0]           paddr,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic      [31:0]           prdata,
    output logic                       pslverr,
    input  wire logic                  mv_req,
    input  wire axm_pkg::axm_move_t    mv,
    output logic                       mv_done,
    input  wire logic                  stk_req,
    input  wire axm_pkg::axm_stack_t   stk,
    output logic                       stk_done,
    output logic      [7:0]            rdata,
    output logic                       busy,
    input  wire logic [7:0]            port_high,
    output logic                       ext_req,
    output axm_pkg::axm_ext_t          ext,
    input  wire logic                  ext_ack,
    input  wire logic [7:0]            ext_rdata,
    output logic                       id_req,
    output axm_pkg::axm_internal_data_space_t        id,
    input  wire logic                  id_ack,
    input  wire logic [7:0]            id_rdata
);
    import axm_pkg::*;

    `include "axm_consts.svh"

    typedef struct packed {
        axm_state_t  st;
        logic [1:0]  cnt;
        logic        stk_op;
        logic [7:0]  sp;
        logic [2:0]  stack_pointer_high;
        logic [7:0]  page;
        logic [7:0]  aux_ctrl;
        logic [7:0]  aux_ctrl2;
        logic [7:0]  nv_ctrl;
        logic [31:0] prdata;
        logic        pslverr;
        logic        ram_en;
        logic        ram_we;
        logic [10:0] ram_addr;
        logic [7:0]  ram_wdata;
        logic        ext_req;
        axm_ext_t    ext;
        logic        id_req;
        axm_internal_data_space_t  id;
        logic        mv_done;
        logic        stk_done;
        logic [7:0]  rdata;
    } axm_regs_t;

    axm_regs_t r;
    axm_regs_t next_r;

    logic [7:0]  ram_q;
    logic [11:0] limit;
    logic [2:0]  size_code;
    logic        bypass;
    logic        nv_window;
    logic        extended_stack_enable;
    logic        acc_stk;
    logic        acc_mv;
    logic [10:0] paged_addr;
    logic        mv_hit;
    logic [10:0] xptr;
    logic [10:0] xptr_inc;
    logic [10:0] xptr_dec;
    logic [7:0]  reg_idx;
    logic        reg_word;

    assign size_code  = r.aux_ctrl[`AXM_SIZE_MSB:`AXM_SIZE_LSB];
    assign bypass     = r.aux_ctrl[`AXM_BYPASS_BIT];
    assign nv_window  = r.nv_ctrl[`AXM_NV_WINDOW_BIT];
    assign extended_stack_enable       = r.aux_ctrl2[`AXM_EXTENDED_STACK_ENABLE_BIT];
    assign busy       = (r.st != AXM_IDLE);
    assign acc_stk    = stk_req && !busy;
    assign acc_mv     = mv_req && !busy && !stk_req;
    assign paged_addr = {r.page[2:0], mv.addr8};
    assign xptr       = {r.stack_pointer_high, r.sp};
    assign xptr_inc   = xptr + 11'h001;
    assign xptr_dec   = xptr - 11'h001;
    assign reg_idx    = paddr[9:2];
    assign reg_word   = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);

    // Size decode; reserved codes fall back to the largest valid size below them.
    always_comb begin
        case (size_code)
            `AXM_CODE_256:  limit = `AXM_LIMIT_256;
            `AXM_CODE_512:  limit = `AXM_LIMIT_512;
            `AXM_CODE_768:  limit = `AXM_LIMIT_768;
            `AXM_CODE_1024: limit = `AXM_LIMIT_1024;
            `AXM_CODE_1152: limit = `AXM_LIMIT_1152;
            default:        limit = `AXM_LIMIT_1152;
        endcase
    end

    // Hit decode for data moves; the stack path never looks at it.
    always_comb begin
        if (bypass) begin
            mv_hit = 1'b0;
        end else if (mv.wide) begin
            mv_hit = !nv_window && (mv.addr16 < {4'h0, limit});
        end else begin
            mv_hit = (r.page <= `AXM_PAGE_MAX) && ({1'b0, paged_addr} < limit);
        end
    end

    always_comb begin
        next_r          = r;
        next_r.mv_done  = 1'b0;
        next_r.stk_done = 1'b0;
        next_r.ram_en   = 1'b0;

        // APB setup cycle captures read data and the error answer.
        if (psel && !penable) begin
            next_r.pslverr = 1'b0;
            next_r.prdata  = 32'h0;
            if (!reg_word) begin
                next_r.pslverr = 1'b1;
            end else begin
                case (reg_idx)
                    `AXM_IDX_SP_LOW:    next_r.prdata = {24'h0, r.sp};
                    `AXM_IDX_SP_HIGH:   next_r.prdata = {29'h0, r.stack_pointer_high};
                    `AXM_IDX_PAGE:      next_r.prdata = {24'h0, r.page};
                    `AXM_IDX_AUX_CTRL:  next_r.prdata = {24'h0, r.aux_ctrl};
                    `AXM_IDX_AUX_CTRL2: next_r.prdata = {24'h0, r.aux_ctrl2};
                    `AXM_IDX_NV_CTRL:   next_r.prdata = {24'h0, r.nv_ctrl};
                    default:            next_r.pslverr = 1'b1;
                endcase
            end
        end

        case (r.st)
            AXM_IDLE: begin
                if (acc_stk) begin
                    next_r.stk_op = 1'b1;
                    if (extended_stack_enable) begin
                        // Extended stack: RAM only, bypass is not consulted.
                        next_r.ram_en    = 1'b1;
                        next_r.ram_we    = stk.push;
                        next_r.ram_wdata = stk.wdata;
                        next_r.ram_addr  = stk.push ? xptr_inc : xptr;
                        next_r.sp        = stk.push ? xptr_inc[7:0] : xptr_dec[7:0];
                        next_r.stack_pointer_high       = stk.push ? xptr_inc[10:8] : xptr_dec[10:8];
                        next_r.cnt       = `AXM_EXTENDED_STACK_ENABLE_WAIT;
                        next_r.st        = AXM_RAM;
                    end else begin
                        // Internal data stack: 8-bit pointer wraps, high byte untouched.
                        next_r.id_req   = 1'b1;
                        next_r.id.write = stk.push;
                        next_r.id.wdata = stk.wdata;
                        next_r.id.addr  = stk.push ? r.sp + 8'h01 : r.sp;
                        next_r.sp       = stk.push ? r.sp + 8'h01 : r.sp - 8'h01;
                        next_r.st       = AXM_IDA;
                    end
                end else if (acc_mv) begin
                    next_r.stk_op = 1'b0;
                    if (mv_hit) begin
                        next_r.ram_en    = 1'b1;
                        next_r.ram_we    = mv.write;
                        next_r.ram_wdata = mv.wdata;
                        next_r.ram_addr  = mv.wide ? mv.addr16[10:0] : paged_addr;
                        next_r.cnt       = `AXM_MOVE_WAIT;
                        next_r.st        = AXM_RAM;
                    end else begin
                        // Paged moves take the high byte from the port register as it stands.
                        next_r.ext_req   = 1'b1;
                        next_r.ext.write = mv.write;
                        next_r.ext.wdata = mv.wdata;
                        next_r.ext.addr  = mv.wide ? mv.addr16 : {port_high, mv.addr8};
                        next_r.st        = AXM_EXT;
                    end
                end
            end
            AXM_RAM: begin
                if (r.cnt == 2'h0) begin
                    next_r.rdata    = ram_q;
                    next_r.mv_done  = !r.stk_op;
                    next_r.stk_done = r.stk_op;
                    next_r.st       = AXM_IDLE;
                end else begin
                    next_r.cnt = r.cnt - 2'h1;
                end
            end
            AXM_EXT: begin
                if (ext_ack) begin
                    next_r.ext_req = 1'b0;
                    next_r.rdata   = ext_rdata;
                    next_r.mv_done = 1'b1;
                    next_r.st      = AXM_IDLE;
                end
            end
            AXM_IDA: begin
                if (id_ack) begin
                    next_r.id_req   = 1'b0;
                    next_r.rdata    = id_rdata;
                    next_r.stk_done = 1'b1;
                    next_r.st       = AXM_IDLE;
                end
            end
            default: begin
                next_r.st      = AXM_IDLE;
                next_r.ext_req = 1'b0;
                next_r.id_req  = 1'b0;
            end
        endcase

        // APB writes land at the access edge and override a same-cycle stack update.
        if (psel && penable && pwrite && reg_word) begin
            case (reg_idx)
                `AXM_IDX_SP_LOW:    next_r.sp        = pwdata[7:0];
                `AXM_IDX_SP_HIGH:   next_r.stack_pointer_high       = pwdata[2:0];
                `AXM_IDX_PAGE:      next_r.page      = pwdata[7:0];
                `AXM_IDX_AUX_CTRL:  next_r.aux_ctrl  = pwdata[7:0];
                `AXM_IDX_AUX_CTRL2: next_r.aux_ctrl2 = pwdata[7:0];
                `AXM_IDX_NV_CTRL:   next_r.nv_ctrl   = pwdata[7:0];
                default:            next_r.sp        = next_r.sp;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r           <= '0;
            r.st        <= AXM_IDLE;
            r.sp        <= `AXM_RST_SP_LOW;
            r.stack_pointer_high       <= `AXM_RST_SP_HIGH;
            r.page      <= `AXM_RST_PAGE;
            r.aux_ctrl  <= `AXM_RST_AUX_CTRL;
            r.aux_ctrl2 <= `AXM_RST_AUX_CTRL2;
            r.nv_ctrl   <= `AXM_RST_NV_CTRL;
        end else begin
            r <= next_r;
        end
    end

    axm_ram #(
        .ADDR_W (RAM_ADDR_W),
        .DATA_W (8)
    ) u_ram (
        .pclk  (pclk),
        .en    (r.ram_en),
        .we    (r.ram_we),
        .addr  (r.ram_addr[RAM_ADDR_W-1:0]),
        .wdata (r.ram_wdata),
        .rdata (ram_q)
    );

    assign pready   = psel && penable;
    assign prdata   = r.prdata;
    assign pslverr  = r.pslverr && psel && penable;
    assign mv_done  = r.mv_done;
    assign stk_done = r.stk_done;
    assign rdata    = r.rdata;
    assign ext_req  = r.ext_req;
    assign ext      = r.ext;
    assign id_req   = r.id_req;
    assign id       = r.id;

    // Checks on the mapping and the stack paths.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_size_reserved: assert property (
        (size_code > `AXM_CODE_1152) |-> (limit == `AXM_LIMIT_1152))
        else $error("reserved size code did not fall back to 1152 bytes");

    a_size_table: assert property (
        (size_code == `AXM_CODE_768) |-> (limit == `AXM_LIMIT_768))
        else $error("size code 768 decoded wrongly");

    a_hit_to_ram: assert property (
        (acc_mv && mv.wide && !bypass && !nv_window && (mv.addr16 < {4'h0, limit}))
        |=> (r.ram_en && !r.ext_req && r.ram_addr == $past(mv.addr16[10:0])))
        else $error("wide move inside the range did not reach the RAM");

    a_above_range: assert property (
        (acc_mv && mv.wide && (mv.addr16 >= {4'h0, limit})) |=> (r.ext_req && !r.ram_en))
        else $error("move above the range was not sent outside");

    a_bypass_ext: assert property (
        (acc_mv && bypass) |=> (r.ext_req && r.st == AXM_EXT))
        else $error("bypass set but move not sent outside");

    a_page_addr: assert property (
        (acc_mv && !mv.wide && mv_hit)
        |=> (r.ram_en && r.ram_addr == {$past(r.page[2:0]), $past(mv.addr8)}))
        else $error("paged address not formed from the page register");

    a_page_high: assert property (
        (acc_mv && !mv.wide && (r.page > `AXM_PAGE_MAX))
        |=> (r.ext_req && r.ext.addr[15:8] == $past(port_high)))
        else $error("page above 07h did not go outside with the port high byte");

    a_nv_window: assert property (
        (acc_mv && mv.wide && nv_window) |=> !r.ram_en)
        else $error("wide move reached the RAM with the window enabled");

    a_move_two: assert property (
        (acc_mv && mv_hit) |=> !mv_done ##1 !mv_done ##1 mv_done)
        else $error("RAM move did not finish on its third cycle");

    a_internal_data_space_stack: assert property (
        (acc_stk && !extended_stack_enable)
        |=> (r.id_req && !r.ram_en && r.stack_pointer_high == $past(r.stack_pointer_high) && r.id.addr == $past(
            stk.push ? r.sp + 8'h01 : r.sp)))
        else $error("internal data stack access malformed");

    a_extended_stack_enable_ram: assert property (
        (acc_stk && extended_stack_enable) |=> (r.ram_en && !r.ext_req && !r.id_req))
        else $error("extended stack access did not use the RAM");

    a_extended_stack_enable_extra: assert property (
        (acc_stk && extended_stack_enable) |=> !stk_done [*3] ##1 stk_done)
        else $error("extended stack access did not take its extra cycle");

    a_extended_stack_enable_bypass: assert property (
        (acc_stk && extended_stack_enable && bypass) |=> (r.st == AXM_RAM))
        else $error("extended stack left the RAM under bypass");

    c_move_hit: cover property (acc_mv && mv_hit ##3 mv_done);
    c_move_ext: cover property (acc_mv && !mv_hit ##[1:20] mv_done);
    c_extended_stack_enable_push: cover property (acc_stk && extended_stack_enable && stk.push ##4 stk_done);
    c_internal_data_space_pop: cover property (acc_stk && !extended_stack_enable && !stk.push ##[1:20] stk_done);

endmodule // axm_map

/* File: bench/axm_far.sv */
// Far-side model: external data memory and internal data space behind the map.
// Assumes one clock; each answer comes after a latency that the bench picks.
module axm_far
    import axm_pkg::*;
(
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic [1:0]          lat,
    input  wire logic                ext_req,
    input  wire axm_pkg::axm_ext_t   ext,
    output logic                     ext_ack,
    output logic      [7:0]          ext_rdata,
    input  wire logic                id_req,
    input  wire axm_pkg::axm_internal_data_space_t id,
    output logic                     id_ack,
    output logic      [7:0]          id_rdata
);
    logic [7:0] xmem [int];
    logic [7:0] imem [int];
    logic [1:0] xcnt;
    logic [1:0] icnt;
    logic       xgo;
    logic       igo;

    assign xgo = ext_req && !ext_ack && xcnt >= lat;
    assign igo = id_req && !id_ack && icnt >= lat;

    // Idle read data toggles each cycle so a stale value never looks valid.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_ack <= 1'b0;
            id_ack <= 1'b0;
            xcnt <= 2'h0;
            icnt <= 2'h0;
            ext_rdata <= 8'h5a;
            id_rdata <= 8'ha5;
        end else begin
            ext_ack <= xgo;
            id_ack <= igo;
            xcnt <= (ext_req && !ext_ack && !xgo) ? xcnt + 2'h1 : 2'h0;
            icnt <= (id_req && !id_ack && !igo) ? icnt + 2'h1 : 2'h0;
            ext_rdata <= !xgo ? ~ext_rdata : xmem.exists(ext.addr) ? xmem[ext.addr] : 8'h00;
            id_rdata <= !igo ? ~id_rdata : imem.exists(id.addr) ? imem[id.addr] : 8'h00;
            if (xgo && ext.write) xmem[ext.addr] = ext.wdata;
            if (igo && id.write) imem[id.addr] = id.wdata;
        end
    end
endmodule // axm_far

/* File: bench/tb_top.sv */
// Self-checking bench for the auxiliary RAM map: APB registers, data moves and stack accesses.
// Assumes axm_far answers external and internal data requests.
`include "axm_consts.svh"
module tb_top import axm_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic        pready, pslverr, mv_req = 0, mv_done, stk_req = 0, stk_done, busy;
    logic        ext_req, ext_ack, id_req, id_ack, byp = 0, nvw = 0, xs = 0;
    axm_move_t   mv = '0;
    axm_stack_t  stk = '0;
    axm_ext_t    ext;
    axm_internal_data_space_t  id;
    logic [7:0]  rdata, ext_rdata, id_rdata, port_high = 8'h00, pg = 8'h00, spl = 8'h07;
    logic [1:0]  lat = 2'h0;
    logic [2:0]  code = 3'h2, sph = 3'h0;
    logic [7:0]  imem [int], dmem [int], xmem [int];
    logic [7:0]  spc [2] = '{8'h07, 8'h40};
    int          error_cnt = 0, n_compared = 0, seed = 63;

    always #12.5 pclk = ~pclk;

    axm_map i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .mv_req(mv_req), .mv(mv), .mv_done(mv_done), .stk_req(stk_req),
        .stk(stk), .stk_done(stk_done), .rdata(rdata), .busy(busy), .port_high(port_high),
        .ext_req(ext_req), .ext(ext), .ext_ack(ext_ack), .ext_rdata(ext_rdata),
        .id_req(id_req), .id(id), .id_ack(id_ack), .id_rdata(id_rdata));
    axm_far i_far (.pclk(pclk), .presetn(presetn), .lat(lat), .ext_req(ext_req), .ext(ext),
        .ext_ack(ext_ack), .ext_rdata(ext_rdata), .id_req(id_req), .id(id), .id_ack(id_ack),
        .id_rdata(id_rdata));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run;
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, idx, d, r, e);
        chk(e, 0);
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp, input logic eexp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, idx, 8'h00, r, e);
        chk(r, exp);
        chk(e, eexp);
    endtask

    task automatic cfg;
        wr(`AXM_IDX_AUX_CTRL, {3'h0, code, byp, 1'b0});
        wr(`AXM_IDX_NV_CTRL, {6'h0, nvw, 1'b0});
        wr(`AXM_IDX_PAGE, pg);
        wr(`AXM_IDX_AUX_CTRL2, {3'h0, xs, 4'h0});
    endtask

    function automatic int lim(input logic [2:0] c);
        case (c)
            3'h0: return 256;
            3'h1: return 512;
            3'h2: return 768;
            3'h3: return 1024;
            default: return 1152;
        endcase
    endfunction

    // Runs one core request; edges are counted from the accept edge to the done sample.
    task automatic core(input logic s, input axm_move_t m, input axm_stack_t k, output int n,
                        output logic x, output logic i, output logic [15:0] xa,
                        output logic [7:0] ia);
        @(posedge pclk);
        if (s) begin
            stk_req <= 1'b1;
            stk <= k;
        end else begin
            mv_req <= 1'b1;
            mv <= m;
        end
        @(posedge pclk);
        mv_req <= 1'b0;
        stk_req <= 1'b0;
        n = 0;
        x = 0;
        i = 0;
        do begin
            @(posedge pclk);
            n++;
            if (n == 1) chk(busy, 1'b1);
            if (ext_req === 1'b1) begin
                x = 1;
                xa = ext.addr;
            end
            if (id_req === 1'b1) begin
                i = 1;
                ia = id.addr;
            end
        end while (((s ? stk_done : mv_done) !== 1'b1) && n < 100);
        chk(busy, 1'b0);
    endtask

    task automatic move(input logic wd, input logic w, input logic [15:0] a16,
                        input logic [7:0] a8);
        int          n, a;
        logic        h, x, i;
        logic [15:0] xa;
        logic [7:0]  ia, d;
        d = 8'($random(seed));
        a = wd ? a16 : {pg[2:0], a8};
        h = !byp && !(wd && nvw) && !(!wd && pg > 8'h07) && a < lim(code);
        core(1'b0, '{wd, w, a16, a8, d}, '0, n, x, i, xa, ia);
        if (h) begin
            chk(n, 3);
            chk(x, 0);
            if (w) imem[a] = d;
            else if (imem.exists(a)) chk(rdata, imem[a]);
        end else begin
            chk(x, 1);
            chk(xa, wd ? a16 : {port_high, a8});
            if (w) xmem[xa] = d;
            else if (xmem.exists(xa)) chk(rdata, xmem[xa]);
        end
    endtask

    task automatic stack(input logic push);
        int          n;
        logic        x, i;
        logic [15:0] xa;
        logic [7:0]  ia, d;
        logic [10:0] p;
        d = 8'($random(seed));
        p = xs ? {sph, spl} : {3'h0, spl};
        if (push) p = xs ? p + 11'h1 : {3'h0, 8'(spl + 8'h01)};
        core(1'b1, '0, '{push, d}, n, x, i, xa, ia);
        chk(x, 0);
        if (xs) begin
            chk(n, 4);
            chk(i, 0);
            if (push) imem[p] = d;
            else if (imem.exists(p)) chk(rdata, imem[p]);
        end else begin
            chk(i, 1);
            chk(ia, p[7:0]);
            if (push) dmem[p[7:0]] = d;
            else if (dmem.exists(p[7:0])) chk(rdata, dmem[p[7:0]]);
        end
        if (!push) p = xs ? p - 11'h1 : {3'h0, 8'(spl - 8'h01)};
        spl = p[7:0];
        if (xs) sph = p[10:8];
    endtask

    initial begin
        logic [15:0] a;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`AXM_IDX_SP_LOW, 32'h07, 1'b0);
        rdc(`AXM_IDX_SP_HIGH, 32'h00, 1'b0);
        rdc(`AXM_IDX_PAGE, 32'h00, 1'b0);
        rdc(`AXM_IDX_AUX_CTRL, 32'h08, 1'b0);
        rdc(8'h00, 32'h00, 1'b1);
        for (int c = 0; c < 8; c++) begin
            code = 3'(c);
            cfg();
            move(1'b1, 1'b1, 16'(lim(code) - 1), 8'h00);
            move(1'b1, 1'b0, 16'(lim(code) - 1), 8'h00);
            move(1'b1, 1'b0, 16'(lim(code)), 8'h00);
        end
        for (int p = 0; p < 9; p++) begin
            pg = 8'(p);
            cfg();
            move(1'b0, 1'b1, 16'h0000, 8'hff);
            move(1'b0, 1'b0, 16'h0000, 8'hff);
        end
        byp = 1;
        xs = 1;
        sph = 3'h2;
        spl = 8'hfe;
        cfg();
        move(1'b1, 1'b0, 16'h0010, 8'h00);
        wr(`AXM_IDX_SP_LOW, spl);
        wr(`AXM_IDX_SP_HIGH, {5'h0, sph});
        repeat (3) stack(1'b1);
        rdc(`AXM_IDX_SP_HIGH, {29'h0, sph}, 1'b0);
        repeat (3) stack(1'b0);
        byp = 0;
        nvw = 1;
        xs = 0;
        spl = 8'hff;
        cfg();
        wr(`AXM_IDX_SP_LOW, spl);
        move(1'b1, 1'b0, 16'h0010, 8'h00);
        stack(1'b1);
        rdc(`AXM_IDX_SP_HIGH, {29'h0, sph}, 1'b0);
        stack(1'b0);
        for (int it = 0; it < 250; it++) begin
            lat <= 2'($random(seed));
            port_high <= 8'($random(seed));
            if ({$random(seed)} % 8 == 0) begin
                code = 3'($random(seed));
                byp = {$random(seed)} % 4 == 0;
                nvw = {$random(seed)} % 4 == 0;
                pg = 8'({$random(seed)} % 10);
                spc[xs] = spl;
                xs = 1'($random(seed));
                spl = spc[xs];
                cfg();
                wr(`AXM_IDX_SP_LOW, spl);
            end
            a = 16'({$random(seed)} % 1280);
            if ({$random(seed)} % 3 == 0) stack(1'($random(seed)));
            else move(1'($random(seed)), 1'($random(seed)), a, a[7:0]);
        end
        rdc(`AXM_IDX_SP_LOW, {24'h0, spl}, 1'b0);
        rdc(`AXM_IDX_SP_HIGH, {29'h0, sph}, 1'b0);
        complete_run();
    end

    initial begin
        #2000000;
        error_cnt++;
        complete_run();
    end
endmodule // tb_top
